// ===== design/ssc_pkg.sv
// Constants shared by the stop mode standby controller.
// Assumes a 20 MHz system clock and a 32-bit APB register port.
`default_nettype none

package ssc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and release timing
   localparam int CLK_PERIOD_NS = 50;
   // Release time with the main clock supply stopped, least value
   localparam int STAB_TIME_NS = 27000;
   localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Post-release waits in system clocks
   localparam logic [3:0] WAIT_VEC_FAST = 4'h8;
   localparam logic [3:0] WAIT_NOVEC_FAST = 4'h2;
   localparam logic [3:0] WAIT_VEC_X1 = 4'ha;
   localparam logic [3:0] WAIT_NOVEC_X1 = 4'h4;

   ////////////////////////////////////////////////////////////////////////
   // CPU clock source codes
   localparam logic [1:0] SRC_HIGH_SPEED_OSC = 2'h0;
   localparam logic [1:0] SRC_CRYSTAL = 2'h1;
   localparam logic [1:0] SRC_EXTERNAL = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam logic [7:0] ADDR_SPEED_MODE = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_WAKE_FLAGS = 8'h08;

   // operation_speed_mode_reg fields
   localparam int BIT_LOW_SPEED_KEEP = 4;
   localparam int BIT_CMP_FILTER_USED = 0;
   localparam logic [31:0] SPEED_MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] SPEED_MODE_MASK = 32'h0000_0011;

   // Status fields
   localparam int BIT_IN_STOP = 0;
   localparam int BIT_CPU_CLK_ON = 1;
   localparam int POS_STATE = 4;

   // Wake flag fields, write one to clear
   localparam int BIT_WAKE_INT = 0;
   localparam int BIT_WAKE_I2C = 1;
   localparam int BIT_WAKE_VEC = 2;

   // Controller states
   typedef enum logic [2:0] {
      SSC_RUN,
      SSC_STOP,
      SSC_STABILIZE,
      SSC_WAIT
   } ssc_state_t;

endpackage

`default_nettype wire

// ===== design/ssc_stop_ctrl.sv
// Stop mode standby controller: clock gating, oscillator control and
// peripheral enables around the processor's stop instruction.
// Assumes core, interrupt controller and option byte run on clk_sys;
// the crystal stable flag comes from another domain and is synchronised.
//
// Behaviour
// R1 - Stop entered only by stop instruction
// R2 - Pending unmasked interrupt releases stop at once
// R3 - Stop gates CPU clock, halts main oscillators
// R4 - Low-speed oscillator follows keep bit, watchdog option
// R5 - Watchdog enabled: oscillator runs if standby-run set
// R6 - Stop halts CPU, flash, RAM, access detection
// R7 - Port latches hold their values during stop
// R8 - Software stops timers, buzzer, ADC, serial first
// R9 - Watchdog counts in stop only with standby-run
// R10 - Comparator runs in stop only without filter
// R11 - I2C address match wakes the device
// R12 - Interval timer, power-on reset, external interrupts run
// R13 - Interrupt releases; after stabilization vector or continue
// R14 - Fast oscillator wait: 8 vectored, 2 otherwise
// R15 - Any reset releases stop
//
// Decided for this implementation: the APB register port and the register offsets.
`default_nettype none

module ssc_stop_ctrl
   import ssc_pkg::*;
#(
   parameter int STAB_COUNT = STAB_CYCLES,
   parameter int CNT_W = 12
) (
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core and interrupt controller
   input wire logic stop_exec,
   input wire logic int_pending_unmasked,
   input wire logic int_ack_enable,
   input wire logic [1:0] cpu_clk_src,
   input wire logic i2c_addr_match,
   // Option byte
   input wire logic watchdog_enable_option,
   input wire logic watchdog_standby_run,
   // Oscillator requests from the clock generator
   input wire logic high_speed_osc_req,
   input wire logic crystal_req,
   input wire logic external_main_req,
   input wire logic crystal_stable,
   // Clock and oscillator controls
   output logic cpu_clk_en,
   output logic high_speed_osc_en,
   output logic crystal_osc_en,
   output logic external_main_en,
   output logic low_speed_osc_en,
   // Peripheral controls
   output logic memory_run,
   output logic port_latch_hold,
   output logic watchdog_run,
   output logic comparator_run,
   output logic i2c_wake_armed,
   output logic always_on_run,
   // Release indications
   output logic release_vector,
   output logic release_next,
   output logic in_stop
);

   ////////////////////////////////////////////////////////////////////////
   // Register and state declarations
   ssc_state_t state_reg;
   ssc_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [31:0] speed_mode_reg;
   logic [2:0] wake_flags_reg;
   logic vector_sel_reg;
   logic x1_src_reg;
   logic xtal_meta_reg;
   logic xtal_sync_reg;
   logic xtal_was_low_reg;
   logic wake;
   logic stopped_clocks;
   logic apb_setup;
   logic apb_write;
   logic addr_ok;
   logic [3:0] wait_len;
   logic keep_low_speed;
   logic cmp_filter_used;
   logic release_pulse;

   // Counter must hold STAB_COUNT - 1; the default width covers counts
   // up to 4096, so a longer release time needs a wider CNT_W
   localparam logic [CNT_W-1:0] STAB_LOAD = CNT_W'(STAB_COUNT - 1);

   assign keep_low_speed = speed_mode_reg[BIT_LOW_SPEED_KEEP];
   assign cmp_filter_used = speed_mode_reg[BIT_CMP_FILTER_USED];

   ////////////////////////////////////////////////////////////////////////
   // Crystal stable flag crosses in from the oscillator domain
   // Only the second flop is read; the first may be metastable
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xtal_meta_reg <= 1'b0;
         xtal_sync_reg <= 1'b0;
      end else begin
         xtal_meta_reg <= crystal_stable;
         xtal_sync_reg <= xtal_meta_reg;
      end
   end

   // Stable flag seen low since stop began. The synchronised flag lags
   // the oscillator by two edges, so after a very short stop it can
   // still show the level from before stop; that stale high must not
   // end the stabilization wait early.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xtal_was_low_reg <= 1'b0;
      end else if (state_reg == SSC_RUN) begin
         xtal_was_low_reg <= 1'b0;
      end else if (!xtal_sync_reg) begin
         xtal_was_low_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake sources: unmasked interrupt or own slave address on I2C
   assign wake = int_pending_unmasked | i2c_addr_match; // R11 R13

   // Post-release wait depends on vectoring and on the CPU clock source
   // External clock uses the fast figures; crystal needs two clocks more
   always_comb begin
      if (x1_src_reg) begin
         wait_len = vector_sel_reg ? WAIT_VEC_X1 : WAIT_NOVEC_X1;
      end else begin
         wait_len = vector_sel_reg ? WAIT_VEC_FAST : WAIT_NOVEC_FAST; // R14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Standby sequencer
   // Stop is held for at least one cycle even when a wake is already
   // pending, so the oscillators see a clean stop and restart.
   // A stop pulse outside run is ignored; run is the only way in.
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         SSC_RUN: begin
            if (stop_exec) begin
               state_next = SSC_STOP; // R1
            end
         end
         SSC_STOP: begin
            if (wake) begin
               state_next = SSC_STABILIZE; // R2 R13
               cnt_next = STAB_LOAD;
            end
         end
         SSC_STABILIZE: begin
            // Crystal source also waits for its own stable flag, and
            // only a flag that has been low since stop counts
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 1'b1;
            end else if (!x1_src_reg || (xtal_sync_reg && xtal_was_low_reg)) begin
               state_next = SSC_WAIT;
               cnt_next = CNT_W'(wait_len - 4'h1);
            end
         end
         SSC_WAIT: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 1'b1;
            end else begin
               state_next = SSC_RUN; // R14
            end
         end
         default: begin
            state_next = SSC_RUN;
            cnt_next = '0;
         end
      endcase
   end

   // State and counter; reset aborts stop from any state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= SSC_RUN; // R15
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Vectoring choice captured on wake, clock source at stop entry
   // Source is latched at the stop edge; a later change has no effect
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vector_sel_reg <= 1'b0;
         x1_src_reg <= 1'b0;
      end else begin
         if (state_reg == SSC_RUN && stop_exec) begin
            x1_src_reg <= (cpu_clk_src == SRC_CRYSTAL);
         end
         if (state_reg == SSC_STOP && wake) begin
            vector_sel_reg <= int_pending_unmasked & int_ack_enable; // R13
         end
      end
   end

   assign release_pulse = (state_reg == SSC_WAIT) && (cnt_reg == '0);

   ////////////////////////////////////////////////////////////////////////
   // Clock and oscillator outputs, registered
   // Main oscillators stay off during stop only; stabilization runs them.
   // Slow oscillator runs outside stop so the watchdog clock pauses only in stop
   assign stopped_clocks = (state_next == SSC_STOP);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cpu_clk_en <= 1'b1;
         high_speed_osc_en <= 1'b1;
         crystal_osc_en <= 1'b0;
         external_main_en <= 1'b0;
         low_speed_osc_en <= 1'b1;
      end else begin
         cpu_clk_en <= (state_next == SSC_RUN); // R3
         high_speed_osc_en <= high_speed_osc_req & ~stopped_clocks; // R3
         crystal_osc_en <= crystal_req & ~stopped_clocks; // R3
         external_main_en <= external_main_req & ~stopped_clocks; // R3
         if (stopped_clocks) begin
            low_speed_osc_en <= keep_low_speed |
               (watchdog_enable_option & watchdog_standby_run); // R4 R5
         end else begin
            low_speed_osc_en <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Peripheral controls, registered
   // Timers, buzzer, ADC and serial array get no gating here: software
   // must stop them before stop, so nothing of theirs is relied on.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         memory_run <= 1'b1;
         port_latch_hold <= 1'b0;
         watchdog_run <= 1'b0;
         comparator_run <= 1'b1;
         i2c_wake_armed <= 1'b0;
         always_on_run <= 1'b1;
         in_stop <= 1'b0;
      end else begin
         memory_run <= (state_next == SSC_RUN); // R6
         port_latch_hold <= (state_next != SSC_RUN); // R7
         watchdog_run <= watchdog_enable_option &
            (~stopped_clocks | watchdog_standby_run); // R9
         comparator_run <= ~stopped_clocks | ~cmp_filter_used; // R10
         i2c_wake_armed <= stopped_clocks; // R11
         always_on_run <= 1'b1; // R12
         in_stop <= stopped_clocks;
      end
   end

   // One-cycle release indications to the core
   // Only one of the pair fires: vectored entry or next instruction
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         release_vector <= 1'b0;
         release_next <= 1'b0;
      end else begin
         release_vector <= release_pulse & vector_sel_reg; // R13
         release_next <= release_pulse & ~vector_sel_reg; // R13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in setup
   // Unmapped offsets answer with an error and leave every register alone
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign addr_ok = (paddr == ADDR_SPEED_MODE) || (paddr == ADDR_STATUS) ||
      (paddr == ADDR_WAKE_FLAGS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // Read mux, registered so prdata is stable through access
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         case (paddr)
            ADDR_SPEED_MODE: prdata <= speed_mode_reg;
            ADDR_STATUS: begin
               prdata <= 32'h0000_0000;
               prdata[BIT_IN_STOP] <= in_stop;
               prdata[BIT_CPU_CLK_ON] <= cpu_clk_en;
               prdata[POS_STATE +: 3] <= state_reg;
            end
            ADDR_WAKE_FLAGS: prdata <= {29'h0000_0000, wake_flags_reg};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Speed mode register; reserved bits stay zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         speed_mode_reg <= SPEED_MODE_RESET;
      end else if (apb_write && paddr == ADDR_SPEED_MODE) begin
         speed_mode_reg <= pwdata & SPEED_MODE_MASK;
      end
   end

   // Sticky wake cause flags; a new wake beats a clearing write
   // Every cause seen at the wake edge is recorded, so several may set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wake_flags_reg <= 3'h0;
      end else begin
         if (apb_write && paddr == ADDR_WAKE_FLAGS) begin
            wake_flags_reg <= wake_flags_reg & ~pwdata[2:0];
         end
         if (state_reg == SSC_STOP && wake) begin
            if (int_pending_unmasked) begin
               wake_flags_reg[BIT_WAKE_INT] <= 1'b1;
            end
            if (i2c_addr_match) begin
               wake_flags_reg[BIT_WAKE_I2C] <= 1'b1;
            end
            if (int_pending_unmasked & int_ack_enable) begin
               wake_flags_reg[BIT_WAKE_VEC] <= 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== tb/ssc_stop_chk.sv
// Port checker for the stop mode standby controller.
// Assumes it is bound into ssc_stop_ctrl and sees only its ports.
`default_nettype none
module ssc_stop_chk
   import ssc_pkg::*;
#(
   parameter int STAB_COUNT = STAB_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic stop_exec,
   input wire logic int_pending_unmasked,
   input wire logic i2c_addr_match,
   input wire logic watchdog_enable_option,
   input wire logic watchdog_standby_run,
   input wire logic cpu_clk_en,
   input wire logic high_speed_osc_en,
   input wire logic crystal_osc_en,
   input wire logic external_main_en,
   input wire logic low_speed_osc_en,
   input wire logic memory_run,
   input wire logic port_latch_hold,
   input wire logic watchdog_run,
   input wire logic i2c_wake_armed,
   input wire logic always_on_run,
   input wire logic release_vector,
   input wire logic release_next,
   input wire logic in_stop
);
   timeunit 1ns;
   timeprecision 1ns;
   // Room for crystal settling, sync and the longest wait
   localparam int REL_MAX = STAB_COUNT + 36;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   property p_entry;
      $rose(in_stop) |-> $past(stop_exec);
   endproperty
   a_entry: assert property (p_entry)
      else $error("stop entered without stop instruction");
   property p_gate;
      in_stop |-> !cpu_clk_en && !high_speed_osc_en && !crystal_osc_en && !external_main_en;
   endproperty
   a_gate: assert property (p_gate)
      else $error("clock or main oscillator running in stop");
   property p_mem;
      in_stop |-> !memory_run && port_latch_hold;
   endproperty
   a_mem: assert property (p_mem)
      else $error("memory running or ports unheld in stop");
   property p_lso;
      in_stop && $past(in_stop) && watchdog_enable_option && watchdog_standby_run
         |-> low_speed_osc_en;
   endproperty
   a_lso: assert property (p_lso)
      else $error("slow oscillator stopped with standby run");
   property p_wdt;
      in_stop && $past(in_stop)
         |-> watchdog_run == (watchdog_enable_option && watchdog_standby_run);
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog run wrong in stop");
   property p_aon;
      in_stop |-> always_on_run && i2c_wake_armed;
   endproperty
   a_aon: assert property (p_aon)
      else $error("wake sources not kept in stop");
   property p_hold;
      in_stop && !int_pending_unmasked && !i2c_addr_match |=> in_stop;
   endproperty
   a_hold: assert property (p_hold)
      else $error("stop left without a wake source");
   property p_rel;
      $fell(in_stop) |-> ##[1:REL_MAX] (release_vector || release_next);
   endproperty
   a_rel: assert property (p_rel)
      else $error("no release after leaving stop");
   property p_pulse;
      (release_vector || release_next) |-> cpu_clk_en && !(release_vector && release_next)
         ##1 !(release_vector || release_next);
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("release pulse malformed");
   c_stop: cover property ($rose(in_stop));
   c_vec: cover property ($rose(release_vector));
   c_next: cover property ($rose(release_next));
endmodule
`default_nettype wire

// ===== tb/ssc_core_model.sv
// Stand-in for the processor core and interrupt controller.
// Assumes its tasks are called just after a rising clk_sys edge.
`default_nettype none
module ssc_core_model #(
   parameter int XTAL_DELAY = 6
) (
   input wire logic clk_sys,
   input wire logic crystal_osc_en,
   input wire logic release_vector,
   input wire logic release_next,
   output logic stop_exec,
   output logic int_pending_unmasked,
   output logic int_ack_enable,
   output logic i2c_addr_match,
   output logic crystal_stable
);
   timeunit 1ns;
   timeprecision 1ns;
   int xtal_cnt = 0;
   initial begin
      stop_exec = 1'b0;
      int_pending_unmasked = 1'b0;
      int_ack_enable = 1'b0;
      i2c_addr_match = 1'b0;
      crystal_stable = 1'b0;
   end
   // Crystal needs time after enable; stable drops one clock after halt
   always @(posedge clk_sys) begin
      xtal_cnt <= !crystal_osc_en ? 0 : (xtal_cnt < XTAL_DELAY) ? xtal_cnt + 1 : xtal_cnt;
      crystal_stable <= crystal_osc_en && (xtal_cnt == XTAL_DELAY);
   end
   // Request is taken or resumed from once released
   always @(posedge clk_sys) begin
      if (release_vector || release_next) begin
         int_pending_unmasked <= 1'b0;
         i2c_addr_match <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Stop instruction; software has halted the other units already
   task automatic exec_stop();
      stop_exec <= 1'b1;
      @(posedge clk_sys);
      stop_exec <= 1'b0;
   endtask
   // Unmasked request, or own-address match alone
   task automatic wake(input logic vec, input logic by_i2c);
      int_ack_enable <= vec;
      int_pending_unmasked <= !by_i2c;
      i2c_addr_match <= by_i2c;
   endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the stop mode standby controller.
// Assumes package, design, checker and core model compiled first.
`default_nettype none
module testbench
   import ssc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic watchdog_enable_option = 1'b0, watchdog_standby_run = 1'b0;
   logic [1:0] cpu_clk_src = 2'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, rerr, stop_exec, int_pending_unmasked, int_ack_enable;
   logic i2c_addr_match, crystal_stable, cpu_clk_en, high_speed_osc_en, crystal_osc_en;
   logic external_main_en, low_speed_osc_en, memory_run, port_latch_hold, watchdog_run;
   logic comparator_run, i2c_wake_armed, always_on_run, release_vector, release_next, in_stop;
   wire logic crystal_req = (cpu_clk_src == SRC_CRYSTAL);
   wire logic external_main_req = (cpu_clk_src == SRC_EXTERNAL);
   int errors = 0, n_tests = 0, cycles = 0, t_vec, t_nov;

   ssc_stop_ctrl #(.STAB_COUNT(4)) i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .stop_exec, .int_pending_unmasked, .int_ack_enable,
      .cpu_clk_src, .i2c_addr_match, .watchdog_enable_option, .watchdog_standby_run,
      .high_speed_osc_req(1'b1), .crystal_req, .external_main_req, .crystal_stable,
      .cpu_clk_en, .high_speed_osc_en, .crystal_osc_en, .external_main_en, .low_speed_osc_en,
      .memory_run, .port_latch_hold, .watchdog_run, .comparator_run, .i2c_wake_armed,
      .always_on_run, .release_vector, .release_next, .in_stop);
   ssc_core_model i_core (.clk_sys, .crystal_osc_en, .release_vector, .release_next,
      .stop_exec, .int_pending_unmasked, .int_ack_enable, .i2c_addr_match, .crystal_stable);

   always #25 clk_sys = ~clk_sys;
   // Cut a hang short; the run needs far fewer cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("Checks %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One APB transfer; an edge passes after release so calls may follow
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Full stop and release; cyc counts cycles up to the release pulse
   task automatic run_stop(input logic keep, w, s, v, input logic [1:0] sel,
      input logic early, by_i2c, output int cyc);
      cyc = 0;
      apb(1'b1, ADDR_SPEED_MODE, {27'h0, keep, 3'h0, s});
      watchdog_enable_option <= w;
      watchdog_standby_run <= s;
      cpu_clk_src <= sel;
      repeat (12) @(posedge clk_sys);
      if (early) i_core.wake(v, by_i2c);
      i_core.exec_stop();
      if (!early) begin
         repeat (2) @(negedge clk_sys);
         chk("stop gating", 32'h1, {26'h0, cpu_clk_en, high_speed_osc_en, crystal_osc_en,
            external_main_en, memory_run, port_latch_hold});
         chk("slow osc", {31'h0, keep | (w & s)}, {31'h0, low_speed_osc_en});
         chk("watchdog", {31'h0, w & s}, {31'h0, watchdog_run});
         chk("comparator", {31'h0, !s}, {31'h0, comparator_run});
         @(posedge clk_sys);
         i_core.wake(v, by_i2c);
      end
      while (release_vector !== 1'b1 && release_next !== 1'b1 && cyc < 100) begin
         @(negedge clk_sys);
         cyc++;
      end
      chk("release kind", {31'h0, v & !by_i2c}, {31'h0, release_vector});
      chk("release run", 32'h2, {30'h0, cpu_clk_en, port_latch_hold});
      @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      // Register reset value, writable bits, refused address
      apb(1'b0, ADDR_SPEED_MODE, 32'h0);
      chk("speed mode reset", SPEED_MODE_RESET, rdata);
      apb(1'b1, ADDR_SPEED_MODE, 32'hffff_ffff);
      apb(1'b0, ADDR_SPEED_MODE, 32'h0);
      chk("speed mode bits", SPEED_MODE_MASK, rdata);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped", 32'h1, {31'h0, rerr});
      // Option and keep-bit combinations for the slow oscillator
      for (int k = 0; k < 4; k++) begin
         run_stop(k == 0, k[1], k[0], k[0], SRC_HIGH_SPEED_OSC, 1'b0, 1'b0, t_vec);
      end
      // Vectored release waits six clocks more on every source
      for (int c = 0; c < 3; c++) begin
         run_stop(1'b1, 1'b0, 1'b0, 1'b1, c[1:0], 1'b0, 1'b0, t_vec);
         run_stop(1'b1, 1'b0, 1'b0, 1'b0, c[1:0], 1'b0, 1'b0, t_nov);
         chk("vector wait extra", 32'h6, t_vec - t_nov);
      end
      // Wake causes recorded, cleared by writing ones
      apb(1'b0, ADDR_WAKE_FLAGS, 32'h0);
      chk("wake flags", 32'h5, rdata);
      apb(1'b1, ADDR_WAKE_FLAGS, 32'h7);
      apb(1'b0, ADDR_WAKE_FLAGS, 32'h0);
      chk("wake flags cleared", 32'h0, rdata);
      run_stop(1'b1, 1'b0, 1'b0, 1'b1, SRC_HIGH_SPEED_OSC, 1'b0, 1'b1, t_vec);
      apb(1'b0, ADDR_WAKE_FLAGS, 32'h0);
      chk("wake flag i2c", 32'h2, rdata);
      run_stop(1'b1, 1'b0, 1'b0, 1'b1, SRC_HIGH_SPEED_OSC, 1'b1, 1'b0, t_vec);
      // Reset in mid-stop returns to run at once
      i_core.exec_stop();
      @(negedge clk_sys);
      chk("in stop", 32'h1, {31'h0, in_stop});
      @(posedge clk_sys);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status in stop", 32'h11, rdata);
      rst <= 1'b1;
      @(negedge clk_sys);
      chk("reset release", 32'h2, {30'h0, cpu_clk_en, in_stop});
      @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status after reset", 32'h2, rdata);
      finish_test();
   end
endmodule

bind ssc_stop_ctrl ssc_stop_chk #(.STAB_COUNT(STAB_COUNT)) i_chk (.clk_sys, .rst, .stop_exec,
   .int_pending_unmasked, .i2c_addr_match, .watchdog_enable_option, .watchdog_standby_run,
   .cpu_clk_en, .high_speed_osc_en, .crystal_osc_en, .external_main_en, .low_speed_osc_en,
   .memory_run, .port_latch_hold, .watchdog_run, .i2c_wake_armed, .always_on_run,
   .release_vector, .release_next, .in_stop);
`default_nettype wire
